// [hdl/txset_pkg.sv]
// Purpose: shared constants and types for the transmitter setting controller
// Assumes: apb with 32-bit data, one word per register
// Notes: all offsets are byte addresses
package txset_pkg;
   localparam int NUM_PRESETS = 16;
   localparam int ALIAS_W = 32;
   // register byte offsets
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_ARG = 8'h04;
   localparam logic [7:0] OFS_ALIAS = 8'h08;
   localparam logic [7:0] OFS_RESULT = 8'h0C;
   localparam logic [7:0] OFS_STATE = 8'h10;
   localparam logic [7:0] OFS_CFG = 8'h14;
   localparam logic [7:0] OFS_SCALE = 8'h18;
   localparam logic [7:0] OFS_ALIAS_RD = 8'h1C;
   // command codes written into the command register
   localparam logic [3:0] CMD_SCRAMBLER = 4'h1;
   localparam logic [3:0] CMD_RECALL = 4'h2;
   localparam logic [3:0] CMD_CARRIER = 4'h3;
   localparam logic [3:0] CMD_STATE_RPT = 4'h4;
   localparam logic [3:0] CMD_POLARITY = 4'h5;
   localparam logic [3:0] CMD_CYCLES = 4'h6;
   localparam logic [3:0] CMD_POT = 4'h7;
   localparam logic [3:0] CMD_INVERT = 4'h8;
   localparam logic [3:0] CMD_STORE = 4'h9;
   localparam logic [3:0] CMD_SCALE = 4'hA;
   // command register field positions
   localparam int CMD_CODE_LSB = 0;
   localparam int CMD_HAS_ARG_BIT = 4;
   localparam int CMD_HAS_ALIAS_BIT = 5;
   // scrambler encodings
   localparam logic [1:0] SCR_OFF = 2'h0;
   localparam logic [1:0] SCR_IRIG = 2'h1;
   localparam logic [1:0] SCR_CCSDS = 2'h2;
   // reset and default values, and result codes
   localparam logic [7:0] POT_DEFAULT = 8'hFF;
   localparam logic [7:0] CYCLES_DEFAULT = 8'h00;
   localparam logic [15:0] SCALE_ONE = 16'h0100;
   localparam logic [7:0] RESULT_OK = 8'h00;
   localparam logic [7:0] RESULT_REJECT = 8'h01;
   localparam logic [7:0] RESULT_BAD_CMD = 8'h02;

   // stored configuration, signed 8.8 deviation scale
   typedef struct packed {
      logic [1:0] scrambler;
      logic carrier_en;
      logic polarity;
      logic [7:0] cycles;
      logic invert;
      logic [15:0] scale;
   } cfg_s;

   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DONE} ctl_e;

   typedef struct packed {
      cfg_s act;
      cfg_s [NUM_PRESETS-1:0] bank;
      logic [NUM_PRESETS-1:0] bank_valid;
      logic [NUM_PRESETS-1:0][ALIAS_W-1:0] alias_name;
      logic [7:0] cmd;
      logic [31:0] arg;
      logic [ALIAS_W-1:0] alias_in;
      logic [7:0] result;
      logic [31:0] reply;
      logic [ALIAS_W-1:0] alias_rd;
      logic [31:0] prdata;
      ctl_e ctl;
   } state_s;
endpackage

// [hdl/transmitter_setting_control.sv]
// Purpose: command interpreter for transmitter settings, reached over apb
// Assumes: inputs synchronous to clk_sys; one command at a time
// Notes: write CMD to start a command; poll RESULT bit 31 for done
//
// Overview of operation
// [R1] scrambler select 0 off, 1 irig, 2 ccsds
// [R2] ccsds only with ldpc option and enabled; a recalled preset still loads ccsds without them
// [R3] recall valid preset copies it to active
// [R4] invalid or bare recall resets defaults, saves
// [R5] carrier enable stored, default by protocol option
// [R6] no valid clock or pin off suppresses carrier
// [R7] polarity 0: pin low means on
// [R8] polarity 1 default: pin high means on
// [R9] inactive on/off pin always forces carrier off
// [R10] cycles per bit times bit rate gives subcarrier
// [R11] pot value readable, default 255, not stored
// [R12] inversion negates deviation scale on top
// [R13] store to preset 0..15, preset 0 at power-on; reset clears the bank, so boot loads defaults
// [R14] store may also keep an alias name
// [R15] state report shows real carrier, modulation activity
// [R16] no argument queries, argument sets
// [R17] deviation scale multiplies default modulation index
// [R18] bad arguments rejected, setting left unchanged
`timescale 1ns/1ps
module transmitter_setting_control (
   input wire logic clk_sys, // system clock, 100 MHz
   input wire logic nrst, // asynchronous reset, active low
   input wire logic clk_en, // freezes all state when low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb write
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic extended_ldpc_option, // extended ldpc fitted
   input wire logic ldpc_enabled, // ldpc coding currently on
   input wire logic alternate_control_protocol_option, // alternate protocol fitted
   input wire logic subcarrier_option, // subcarrier option fitted
   input wire logic hw_preset_enable, // hardware preset selection on
   input wire logic [3:0] hw_preset_sel, // hardware preset number
   input wire logic clock_valid, // a valid data clock is in use
   input wire logic onoff_pin, // external on/off pin level
   input wire logic modulation_on, // datapath modulation active
   input wire logic [7:0] amplifier_pot_value, // amplifier pot readback
   input wire logic [15:0] modulation_index_default, // standard index, 8.8
   input wire logic [23:0] bit_rate, // bit rate in bit/s
   output logic [1:0] scrambler_select, // active scrambler selection
   output logic carrier_output_enable, // stored software carrier control
   output logic onoff_pin_polarity, // stored pin polarity
   output logic [7:0] cycles_per_bit_setting, // stored cycles per bit
   output logic [31:0] subcarrier_freq, // subcarrier frequency in Hz
   output logic [15:0] deviation_scale, // effective signed scale, 8.8
   output logic [15:0] modulation_index, // scaled index, signed 8.8
   output logic carrier_on, // carrier actually radiating
   output logic [1:0] output_state_report // {modulation on, carrier on}
);
   import txset_pkg::*;

   state_s cur_ff;
   state_s nxt_ff;
   logic pin_active;
   logic carrier_gate;
   logic [7:0] addr_lo;
   logic [3:0] code;
   logic has_arg;
   logic [3:0] arg_idx;
   logic wr_acc;
   logic rd_acc;
   logic mapped;
   logic [31:0] mult_full;
   logic [31:0] sub_full;
   logic [15:0] eff_scale;
   cfg_s dflt;

   // pin polarity decode, the pin is pulled up so floating reads high
   assign pin_active = cur_ff.act.polarity ? onoff_pin : ~onoff_pin; // [R7] [R8]
   // the pin beats every other setting
   assign carrier_gate = pin_active & clock_valid & cur_ff.act.carrier_en; // [R6] [R9]

   // factory defaults depend on fitted options
   always_comb begin
      dflt = '0;
      dflt.scrambler = SCR_OFF; // [R1]
      dflt.carrier_en = ~alternate_control_protocol_option; // [R5]
      dflt.polarity = 1'b1; // [R8]
      dflt.cycles = CYCLES_DEFAULT;
      dflt.invert = 1'b0;
      dflt.scale = SCALE_ONE;
   end

   // inversion is a sign flip on top of the stored scale
   assign eff_scale = cur_ff.act.invert ? 16'(-cur_ff.act.scale) : cur_ff.act.scale; // [R12]
   assign mult_full = 32'($signed(eff_scale) * $signed(modulation_index_default)); // [R17]
   assign sub_full = 32'(cur_ff.act.cycles) * 32'(bit_rate); // [R10]

   assign addr_lo = paddr;
   assign code = cur_ff.cmd[CMD_CODE_LSB +: 4];
   assign has_arg = cur_ff.cmd[CMD_HAS_ARG_BIT];
   assign arg_idx = cur_ff.arg[3:0];
   assign wr_acc = psel & penable & pwrite & clk_en;
   assign rd_acc = psel & ~penable & ~pwrite & clk_en;
   assign mapped = (paddr[1:0] == 2'h0) && (paddr <= OFS_ALIAS_RD);

   // all state but boot_ff in one struct; command engine and bus in one process
   always_comb begin
      nxt_ff = cur_ff;
      // bus writes; a busy engine ignores new commands
      if (wr_acc && mapped) begin
         unique case (addr_lo)
            OFS_CMD: begin
               if (cur_ff.ctl != ST_EXEC) begin
                  nxt_ff.cmd = pwdata[7:0];
                  nxt_ff.ctl = ST_EXEC;
               end
            end
            OFS_ARG: nxt_ff.arg = pwdata;
            OFS_ALIAS: nxt_ff.alias_in = pwdata;
            default: begin
            end
         endcase
      end
      // read data is latched in setup so it is stable in access
      if (rd_acc) begin
         unique case (addr_lo)
            OFS_CMD: nxt_ff.prdata = {24'h0, cur_ff.cmd};
            OFS_ARG: nxt_ff.prdata = cur_ff.arg;
            OFS_ALIAS: nxt_ff.prdata = cur_ff.alias_in;
            OFS_RESULT: nxt_ff.prdata = {cur_ff.ctl == ST_DONE, 23'h0, cur_ff.result};
            OFS_STATE: nxt_ff.prdata = {30'h0, modulation_on & carrier_gate, carrier_gate}; // [R15]
            OFS_CFG: nxt_ff.prdata = cur_ff.reply;
            OFS_SCALE: nxt_ff.prdata = {16'h0, eff_scale};
            OFS_ALIAS_RD: nxt_ff.prdata = cur_ff.alias_rd;
            default: nxt_ff.prdata = 32'h0;
         endcase
      end
      // execute one command in a single cycle
      if (clk_en && cur_ff.ctl == ST_EXEC) begin
         nxt_ff.ctl = ST_DONE;
         nxt_ff.result = RESULT_OK;
         unique case (code)
            CMD_SCRAMBLER: begin
               if (!has_arg) begin
                  nxt_ff.reply = {30'h0, cur_ff.act.scrambler}; // [R16]
               end else if (cur_ff.arg == 32'(SCR_OFF) || cur_ff.arg == 32'(SCR_IRIG)) begin
                  nxt_ff.act.scrambler = cur_ff.arg[1:0]; // [R1]
               end else if (cur_ff.arg == 32'(SCR_CCSDS) && extended_ldpc_option && ldpc_enabled) begin
                  nxt_ff.act.scrambler = SCR_CCSDS; // [R2]
               end else begin
                  nxt_ff.result = RESULT_REJECT; // [R18]
               end
            end
            CMD_RECALL: begin
               if (has_arg && cur_ff.arg > 32'(NUM_PRESETS - 1)) begin
                  nxt_ff.result = RESULT_REJECT; // [R18]
               end else if (has_arg && cur_ff.bank_valid[arg_idx]) begin
                  nxt_ff.act = cur_ff.bank[arg_idx]; // [R3]
               end else begin
                  // bare recall aims at preset 0
                  nxt_ff.act = dflt; // [R4]
                  nxt_ff.bank[has_arg ? arg_idx : 4'h0] = dflt; // [R4]
                  nxt_ff.bank_valid[has_arg ? arg_idx : 4'h0] = 1'b1; // [R4]
               end
            end
            CMD_CARRIER: begin
               if (!has_arg) begin
                  nxt_ff.reply = {31'h0, cur_ff.act.carrier_en}; // [R16]
               end else if (cur_ff.arg <= 32'h1) begin
                  nxt_ff.act.carrier_en = cur_ff.arg[0]; // [R5]
               end else begin
                  nxt_ff.result = RESULT_REJECT; // [R18]
               end
            end
            CMD_STATE_RPT: nxt_ff.reply = {30'h0, modulation_on & carrier_gate, carrier_gate}; // [R15]
            CMD_POLARITY: begin
               if (!has_arg) begin
                  nxt_ff.reply = {31'h0, cur_ff.act.polarity}; // [R16]
               end else if (cur_ff.arg <= 32'h1) begin
                  nxt_ff.act.polarity = cur_ff.arg[0]; // [R7] [R8]
               end else begin
                  nxt_ff.result = RESULT_REJECT; // [R18]
               end
            end
            CMD_CYCLES: begin
               if (!subcarrier_option || (has_arg && cur_ff.arg > 32'hFF)) begin
                  nxt_ff.result = RESULT_REJECT; // [R18]
               end else if (!has_arg) begin
                  nxt_ff.reply = {24'h0, cur_ff.act.cycles}; // [R16]
               end else begin
                  nxt_ff.act.cycles = cur_ff.arg[7:0]; // [R10]
               end
            end
            CMD_POT: nxt_ff.reply = {24'h0, amplifier_pot_value}; // [R11]
            CMD_INVERT: begin
               if (!has_arg) begin
                  nxt_ff.reply = {31'h0, cur_ff.act.invert}; // [R16]
               end else if (cur_ff.arg <= 32'h1) begin
                  nxt_ff.act.invert = cur_ff.arg[0]; // [R12]
               end else begin
                  nxt_ff.result = RESULT_REJECT; // [R18]
               end
            end
            CMD_SCALE: begin
               if (!has_arg) begin
                  nxt_ff.reply = {16'h0, cur_ff.act.scale}; // [R16]
               end else begin
                  nxt_ff.act.scale = cur_ff.arg[15:0]; // [R17]
               end
            end
            CMD_STORE: begin
               if (!has_arg || cur_ff.arg > 32'(NUM_PRESETS - 1)) begin
                  nxt_ff.result = RESULT_REJECT; // [R18]
               end else begin
                  nxt_ff.bank[arg_idx] = cur_ff.act; // [R13]
                  nxt_ff.bank_valid[arg_idx] = 1'b1; // [R13]
                  if (cur_ff.cmd[CMD_HAS_ALIAS_BIT]) begin
                     nxt_ff.alias_name[arg_idx] = cur_ff.alias_in; // [R14]
                  end
                  nxt_ff.alias_rd = cur_ff.alias_name[arg_idx];
                  if (cur_ff.cmd[CMD_HAS_ALIAS_BIT]) begin
                     nxt_ff.alias_rd = cur_ff.alias_in;
                  end
               end
            end
            default: nxt_ff.result = RESULT_BAD_CMD;
         endcase
      end
   end

   // power-on load after reset release; reset clears bank_valid, so defaults are loaded, never a preset
   logic boot_ff;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         boot_ff <= 1'b1;
      end else if (clk_en) begin
         boot_ff <= 1'b0;
      end
   end

   // register the whole state; reset takes constants only
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cur_ff <= '0;
         cur_ff.act.polarity <= 1'b1;
         cur_ff.act.carrier_en <= 1'b0;
         cur_ff.act.scale <= SCALE_ONE;
         cur_ff.ctl <= ST_IDLE;
      end else if (clk_en) begin
         cur_ff <= nxt_ff;
         if (boot_ff) begin
            // strap options are sampled here, after release
            if (hw_preset_enable && cur_ff.bank_valid[hw_preset_sel]) begin
               cur_ff.act <= cur_ff.bank[hw_preset_sel]; // [R13]
            end else if (cur_ff.bank_valid[0]) begin
               cur_ff.act <= cur_ff.bank[0]; // [R13]
            end else begin
               cur_ff.act <= dflt; // [R5]
            end
         end
      end
   end

   // apb answers with zero wait states
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata = cur_ff.prdata;
   assign scrambler_select = cur_ff.act.scrambler;
   assign carrier_output_enable = cur_ff.act.carrier_en;
   assign onoff_pin_polarity = cur_ff.act.polarity;
   assign cycles_per_bit_setting = cur_ff.act.cycles;
   assign subcarrier_freq = subcarrier_option ? sub_full : 32'h0; // [R10]
   assign deviation_scale = eff_scale;
   assign modulation_index = mult_full[23:8]; // [R17]
   assign carrier_on = carrier_gate; // [R6]
   assign output_state_report = {modulation_on & carrier_gate, carrier_gate}; // [R15]

   // assertions
   // ccsds entered outside the boot cycle
   sequence s_enter_ccsds;
      (clk_en && !boot_ff && scrambler_select != SCR_CCSDS) ##1 (scrambler_select == SCR_CCSDS && !boot_ff);
   endsequence
   // carrier command with an illegal argument
   sequence s_bad_carrier_arg;
      clk_en && cur_ff.ctl == ST_EXEC && code == CMD_CARRIER && has_arg && cur_ff.arg > 32'h1;
   endsequence

   // pin and clock each gate the carrier
   a_pin_forces_off: assert property (@(posedge clk_sys) disable iff (!nrst) // [R9]
      !pin_active |-> !carrier_on)
      else $error("carrier on with pin inactive");

   a_no_clock_off: assert property (@(posedge clk_sys) disable iff (!nrst) // [R6]
      !clock_valid |-> !carrier_on)
      else $error("carrier on without clock");

   // polarity decode of the pin
   a_pol_low_on: assert property (@(posedge clk_sys) disable iff (!nrst) // [R7]
      (!onoff_pin_polarity && onoff_pin) |-> !carrier_on)
      else $error("pin high active in low polarity");

   a_pol_high_on: assert property (@(posedge clk_sys) disable iff (!nrst) // [R8]
      (onoff_pin_polarity && onoff_pin && clock_valid && carrier_output_enable) |-> carrier_on)
      else $error("pin high not active");

   // scrambler codes and ccsds gating
   a_scr_legal: assert property (@(posedge clk_sys) disable iff (!nrst) // [R1]
      scrambler_select != 2'h3)
      else $error("illegal scrambler code");

   a_ccsds_gated: assert property (@(posedge clk_sys) disable iff (!nrst) // [R2]
      s_enter_ccsds
      |-> $past(extended_ldpc_option) && $past(ldpc_enabled) || $past(code) == CMD_RECALL)
      else $error("ccsds without ldpc");

   // inversion and report
   a_invert_sign: assert property (@(posedge clk_sys) disable iff (!nrst) // [R12]
      cur_ff.act.invert |-> deviation_scale == 16'(-cur_ff.act.scale))
      else $error("inversion not applied");

   a_report_match: assert property (@(posedge clk_sys) disable iff (!nrst) // [R15]
      output_state_report[0] == (pin_active && clock_valid && carrier_output_enable))
      else $error("report disagrees with gating");

   // refused argument keeps the setting
   a_reject_keep: assert property (@(posedge clk_sys) disable iff (!nrst || boot_ff) // [R18]
      s_bad_carrier_arg |=> $stable(carrier_output_enable) && cur_ff.result == RESULT_REJECT)
      else $error("bad arg changed setting");

   // subcarrier needs its option
   a_sub_freq: assert property (@(posedge clk_sys) disable iff (!nrst) // [R10]
      !subcarrier_option |-> subcarrier_freq == 32'h0)
      else $error("subcarrier without option");

   // bare recall lands on defaults
   a_recall_dflt: assert property (@(posedge clk_sys) disable iff (!nrst) // [R4]
      (clk_en && cur_ff.ctl == ST_EXEC && code == CMD_RECALL && !has_arg)
      |=> scrambler_select == SCR_OFF && onoff_pin_polarity && deviation_scale == SCALE_ONE)
      else $error("bare recall missed defaults");

   // a command takes one enabled edge
   a_exec_once: assert property (@(posedge clk_sys) disable iff (!nrst) // [R16]
      (clk_en && cur_ff.ctl == ST_EXEC) |=> cur_ff.ctl == ST_DONE)
      else $error("command engine stuck busy");
endmodule

// [test/host_terminal.sv]
// Purpose: host terminal model, issues setting commands over apb
// Assumes: pready sampled at rising edges; one transfer at a time
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/1ps
module host_terminal (
   input wire logic clk_sys, // system clock
   output logic psel, // apb select
   output logic penable, // apb access phase
   output logic pwrite, // apb write
   output logic [7:0] paddr, // apb byte address
   output logic [31:0] pwdata, // apb write data
   input wire logic [31:0] prdata, // apb read data
   input wire logic pready, // apb ready
   input wire logic pslverr // apb error
);
   logic err_seen; // pslverr taken at the last access edge
   // bus idles deselected from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      err_seen = 1'b0;
   end
   // one transfer; request held until pready is seen high, bench timeout bounds it
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata, output logic [31:0] rdata);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdata;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) begin
         @(posedge clk_sys);
      end
      rdata = prdata;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~addr; // stale values would hide a late sample
      pwdata <= ~wdata;
      // idle edge, so a next call never reassigns psel now
      @(posedge clk_sys);
   endtask
endmodule

// [test/transmitter_setting_control_test.sv]
// Purpose: self-checking bench for the transmitter setting controller
// Assumes: 100 MHz clock, apb host model drives the register bus
// Notes: each scenario is its own task and judges its own results
`timescale 1ns/1ps
module transmitter_setting_control_test;
   import txset_pkg::*;
   logic clk_sys, nrst, clk_en, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, amplifier_pot_value, cycles_per_bit_setting;
   logic [31:0] pwdata, prdata, subcarrier_freq;
   logic extended_ldpc_option, ldpc_enabled, alternate_control_protocol_option, subcarrier_option;
   logic hw_preset_enable, clock_valid, onoff_pin, modulation_on, carrier_output_enable, onoff_pin_polarity;
   logic carrier_on;
   logic [3:0] hw_preset_sel;
   logic [15:0] modulation_index_default, deviation_scale, modulation_index;
   logic [23:0] bit_rate;
   logic [1:0] scrambler_select, output_state_report;
   int err_count, comparisons, cycles;
   transmitter_setting_control uut (.clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .extended_ldpc_option(extended_ldpc_option), .ldpc_enabled(ldpc_enabled),
      .alternate_control_protocol_option(alternate_control_protocol_option), .subcarrier_option(subcarrier_option),
      .hw_preset_enable(hw_preset_enable), .hw_preset_sel(hw_preset_sel), .clock_valid(clock_valid),
      .onoff_pin(onoff_pin), .modulation_on(modulation_on), .amplifier_pot_value(amplifier_pot_value),
      .modulation_index_default(modulation_index_default), .bit_rate(bit_rate), .scrambler_select(scrambler_select),
      .carrier_output_enable(carrier_output_enable), .onoff_pin_polarity(onoff_pin_polarity),
      .cycles_per_bit_setting(cycles_per_bit_setting), .subcarrier_freq(subcarrier_freq),
      .deviation_scale(deviation_scale), .modulation_index(modulation_index), .carrier_on(carrier_on),
      .output_state_report(output_state_report));
   host_terminal host (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // clock source
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // hang guard, generous against about eight hundred cycles of traffic
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         complete_run();
      end
   end
   // argument then command, one idle cycle for execution, then result
   task automatic run_cmd(input logic [5:0] op, input logic [31:0] arg, input logic [7:0] exp_res);
      logic [31:0] r;
      host.xfer(1'b1, OFS_ARG, arg, r);
      host.xfer(1'b1, OFS_CMD, {26'h0, op}, r);
      @(posedge clk_sys);
      host.xfer(1'b0, OFS_RESULT, 32'h0, r);
      check({31'h0, r[31]}, 32'h1);
      check({24'h0, r[7:0]}, {24'h0, exp_res});
   endtask
   task automatic query(input logic [3:0] code, input logic [31:0] exp);
      logic [31:0] r;
      run_cmd({2'b00, code}, 32'h0, RESULT_OK);
      host.xfer(1'b0, OFS_CFG, 32'h0, r);
      check(r, exp);
   endtask
   task automatic defaults_after_reset();
      check(32'(scrambler_select), 32'h0);
      check(32'(carrier_output_enable), 32'h1);
      check(32'(onoff_pin_polarity), 32'h1);
      check(32'(cycles_per_bit_setting), 32'h0);
      check(32'(deviation_scale), 32'h00000100);
      check(32'(modulation_index), 32'h000000B3);
      check(32'(pready), 32'h1);
      query(CMD_SCRAMBLER, 32'h0);
      query(CMD_POLARITY, 32'h1);
      query(CMD_POT, 32'h000000FF);
   endtask
   task automatic scrambler_modes();
      logic [31:0] r;
      run_cmd({2'b01, CMD_SCRAMBLER}, 32'h1, RESULT_OK);
      check(32'(scrambler_select), 32'(SCR_IRIG));
      run_cmd({2'b01, CMD_SCRAMBLER}, 32'h2, RESULT_REJECT);
      extended_ldpc_option <= 1'b1;
      run_cmd({2'b01, CMD_SCRAMBLER}, 32'h2, RESULT_REJECT);
      check(32'(scrambler_select), 32'(SCR_IRIG));
      ldpc_enabled <= 1'b1;
      run_cmd({2'b01, CMD_SCRAMBLER}, 32'h2, RESULT_OK);
      run_cmd({2'b01, CMD_SCRAMBLER}, 32'h3, RESULT_REJECT);
      query(CMD_SCRAMBLER, 32'(SCR_CCSDS));
      run_cmd({2'b01, CMD_SCRAMBLER}, 32'h0, RESULT_OK);
      check(32'(scrambler_select), 32'(SCR_OFF));
      // a frozen block ignores the bus
      clk_en <= 1'b0;
      host.xfer(1'b1, OFS_ARG, 32'h1, r);
      host.xfer(1'b1, OFS_CMD, {26'h0, 2'b01, CMD_SCRAMBLER}, r);
      @(posedge clk_sys);
      check(32'(scrambler_select), 32'(SCR_OFF));
      clk_en <= 1'b1;
   endtask
   // every mix of polarity, pin level, clock validity and software control
   task automatic carrier_gating();
      logic [31:0] r;
      logic on;
      for (int i = 0; i < 16; i++) begin
         run_cmd({2'b01, CMD_POLARITY}, 32'(i[0]), RESULT_OK);
         run_cmd({2'b01, CMD_CARRIER}, 32'(i[3]), RESULT_OK);
         onoff_pin <= i[1];
         clock_valid <= i[2];
         modulation_on <= ~i[0];
         @(posedge clk_sys);
         @(posedge clk_sys);
         on = (i[1] == i[0]) & i[2] & i[3];
         check(32'(carrier_on), 32'(on));
         check(32'(output_state_report), {30'h0, on & ~i[0], on});
         host.xfer(1'b0, OFS_STATE, 32'h0, r);
         check({30'h0, r[1:0]}, {30'h0, on & ~i[0], on});
      end
      run_cmd({2'b01, CMD_CARRIER}, 32'h2, RESULT_REJECT);
      query(CMD_CARRIER, 32'h1);
   endtask
   task automatic subcarrier_cycles();
      run_cmd({2'b01, CMD_CYCLES}, 32'h5, RESULT_REJECT);
      check(32'(cycles_per_bit_setting), 32'h0);
      subcarrier_option <= 1'b1;
      bit_rate <= 24'h002580;
      run_cmd({2'b01, CMD_CYCLES}, 32'h5, RESULT_OK);
      check(subcarrier_freq, 32'h0000BB80);
      query(CMD_CYCLES, 32'h5);
   endtask
   task automatic scale_and_inversion();
      logic [31:0] r;
      run_cmd({2'b01, CMD_SCALE}, 32'h00000200, RESULT_OK);
      check(32'(modulation_index), 32'h00000166);
      run_cmd({2'b01, CMD_INVERT}, 32'h1, RESULT_OK);
      check(32'(deviation_scale), 32'h0000FE00);
      check(32'(modulation_index), 32'h0000FE9A);
      host.xfer(1'b0, OFS_SCALE, 32'h0, r);
      check({16'h0, r[15:0]}, 32'h0000FE00);
      run_cmd({2'b01, CMD_INVERT}, 32'h0, RESULT_OK);
      check(32'(deviation_scale), 32'h00000200);
   endtask
   task automatic presets();
      logic [31:0] r;
      amplifier_pot_value <= 8'h5A;
      query(CMD_POT, 32'h0000005A);
      run_cmd({2'b01, CMD_SCRAMBLER}, 32'h1, RESULT_OK);
      host.xfer(1'b1, OFS_ALIAS, 32'h41424344, r);
      run_cmd({2'b11, CMD_STORE}, 32'hF, RESULT_OK);
      host.xfer(1'b0, OFS_ALIAS_RD, 32'h0, r);
      check(r, 32'h41424344);
      run_cmd({2'b01, CMD_SCRAMBLER}, 32'h0, RESULT_OK);
      run_cmd({2'b01, CMD_RECALL}, 32'hF, RESULT_OK);
      check(32'(scrambler_select), 32'h1);
      check(32'(deviation_scale), 32'h00000200);
      alternate_control_protocol_option <= 1'b1;
      run_cmd({2'b01, CMD_RECALL}, 32'h3, RESULT_OK);
      check(32'(scrambler_select), 32'h0);
      check(32'(deviation_scale), 32'h00000100);
      check(32'(carrier_output_enable), 32'h0);
      run_cmd({2'b01, CMD_SCRAMBLER}, 32'h1, RESULT_OK);
      run_cmd({2'b01, CMD_STORE}, 32'h0, RESULT_OK);
      run_cmd({2'b01, CMD_INVERT}, 32'h1, RESULT_OK);
      run_cmd({2'b00, CMD_RECALL}, 32'h0, RESULT_OK);
      check(32'(scrambler_select), 32'h0);
      check(32'(deviation_scale), 32'h00000100);
      run_cmd({2'b01, CMD_SCRAMBLER}, 32'h1, RESULT_OK);
      run_cmd({2'b01, CMD_RECALL}, 32'h0, RESULT_OK);
      check(32'(scrambler_select), 32'h0);
      run_cmd({2'b01, CMD_RECALL}, 32'h10, RESULT_REJECT);
      run_cmd({2'b00, CMD_STORE}, 32'h0, RESULT_REJECT);
      run_cmd({2'b00, 4'hF}, 32'h0, RESULT_BAD_CMD);
      host.xfer(1'b0, 8'h20, 32'h0, r);
      check(32'(host.err_seen), 32'h1);
   endtask
   // main sequence: inputs at time zero, reset for two cycles, scenarios
   initial begin
      err_count = 0;
      comparisons = 0;
      cycles = 0;
      nrst = 1'b0;
      clk_en = 1'b1;
      extended_ldpc_option = 1'b0;
      ldpc_enabled = 1'b0;
      alternate_control_protocol_option = 1'b0;
      subcarrier_option = 1'b0;
      hw_preset_enable = 1'b0;
      hw_preset_sel = 4'h0;
      clock_valid = 1'b1;
      onoff_pin = 1'b1;
      modulation_on = 1'b1;
      amplifier_pot_value = 8'hFF;
      modulation_index_default = 16'h00B3;
      bit_rate = 24'h000000;
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      defaults_after_reset();
      scrambler_modes();
      carrier_gating();
      subcarrier_cycles();
      scale_and_inversion();
      presets();
      complete_run();
   end
endmodule
